// ===== kbi_map.vh
`ifndef KBI_MAP_VH
`define KBI_MAP_VH
// Register word offsets (byte address = 4 * index)
`define REG_STATUS_CTRL_IDX   2'h0
`define REG_KB_ENABLE_IDX     2'h1
`define REG_IDX_W             2
// Status/control field positions
`define F_LEVEL_K             0
`define F_MASK_K              1
`define F_ACK_K               2
`define F_PEND_K              3
`define F_LEVEL_E             4
`define F_MASK_E              5
`define F_ACK_E               6
`define F_PEND_E              7
// Reset values and keyboard pin count
`define RST_CTRL              1'h0
`define RST_KB_EN             6'h00
`define KB_PINS               6
// Edges counted after reset before the synchroniser output is trusted
`define SYNC_WARM             2'h3
`endif

// ===== keyboard_external_interrupt.v
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "kbi_map.vh"

module keyboard_external_interrupt #(
   parameter KB_N = `KB_PINS
) (
   input  wire              ref_clk,
   input  wire              reset_n,
   // Avalon-MM slave
   input  wire [3:0]        avs_address,
   input  wire              avs_read,
   input  wire              avs_write,
   input  wire [31:0]       avs_writedata,
   input  wire [3:0]        avs_byteenable,
   output reg  [31:0]       avs_readdata,
   output wire              avs_waitrequest,
   // Pins and system
   input  wire              ext_int_pin,
   input  wire [KB_N-1:0]   kb_pin,
   input  wire              vector_fetch_ack,
   input  wire              break_state,
   input  wire              break_clear_en,
   output wire              cpu_irq,
   output wire [KB_N-1:0]   kb_pullup_en,
   output wire [KB_N-1:0]   kb_force_input
);

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   reg  [KB_N-1:0]  kb_pin_en_ff;      // Keyboard enable bits
   reg              ext_level_sel_ff;  // External level sensitivity
   reg              kb_level_sel_ff;   // Keyboard level sensitivity
   reg              ext_mask_ff;       // External mask
   reg              kb_mask_ff;        // Keyboard mask
   reg              ext_latch_ff;      // External request latch
   reg              kb_latch_ff;       // Keyboard request latch
   reg              ext_s1_ff;         // Sync stage 1
   reg              ext_s2_ff;         // Sync stage 2
   reg  [KB_N-1:0]  kb_s1_ff;          // Sync stage 1
   reg  [KB_N-1:0]  kb_s2_ff;          // Sync stage 2
   reg              ext_prev_ff;       // Previous synced external level
   reg              kb_and_prev_ff;    // Previous AND of enabled pins
   reg              ack_seen_e_ff;     // Acknowledge waiting for pin high
   reg              ack_seen_k_ff;     // Acknowledge waiting for pins high
   reg              wr_done_ff;        // Single wait-state for access
   reg  [1:0]       warm_ff;           // Edges since reset, saturating
   wire             sync_ready;        // Synchroniser and edge history valid
   wire             kb_and;            // All enabled pins high
   wire             ext_fall;
   wire             kb_fall;
   wire             wr_hit;
   wire             ack_allow;
   wire             sw_ack_e;
   wire             sw_ack_k;
   wire             clr_e;
   wire             clr_k;
   wire             set_e;
   wire             set_k;
   wire [`REG_IDX_W-1:0] idx;

   // ------------------------------------------------------------
   // Bus slave: one wait cycle, then answer
   // ------------------------------------------------------------
   // Decoding a word index from byte address
   function [`REG_IDX_W-1:0] word_idx;
      input [3:0] a;
      begin
         word_idx = a[3:2];
      end
   endfunction

   assign idx             = word_idx(avs_address);
   assign avs_waitrequest = (avs_read | avs_write) & ~wr_done_ff;
   assign wr_hit          = avs_write & wr_done_ff & avs_byteenable[0];

   // Access done toggles so each request takes exactly two edges
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_done_ff <= 1'b0;
      end else begin
         wr_done_ff <= (avs_read | avs_write) & ~wr_done_ff;
      end
   end

   // Register writes
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_level_sel_ff <= `RST_CTRL;
         kb_level_sel_ff  <= `RST_CTRL;
         ext_mask_ff      <= `RST_CTRL;
         kb_mask_ff       <= `RST_CTRL;
         kb_pin_en_ff     <= `RST_KB_EN;
      end else if (wr_hit) begin
         if (idx == `REG_STATUS_CTRL_IDX) begin
            ext_level_sel_ff <= avs_writedata[`F_LEVEL_E];
            kb_level_sel_ff  <= avs_writedata[`F_LEVEL_K];
            ext_mask_ff      <= avs_writedata[`F_MASK_E];
            kb_mask_ff       <= avs_writedata[`F_MASK_K];
         end else if (idx == `REG_KB_ENABLE_IDX) begin
            kb_pin_en_ff <= avs_writedata[KB_N-1:0];
         end
      end
   end

   // Read data; unmapped words read zero
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~wr_done_ff) begin
         avs_readdata <= 32'h0;
         if (idx == `REG_STATUS_CTRL_IDX) begin
            avs_readdata[`F_PEND_E]  <= ext_latch_ff;
            avs_readdata[`F_PEND_K]  <= kb_latch_ff;
            avs_readdata[`F_LEVEL_E] <= ext_level_sel_ff;
            avs_readdata[`F_LEVEL_K] <= kb_level_sel_ff;
            avs_readdata[`F_MASK_E]  <= ext_mask_ff;
            avs_readdata[`F_MASK_K]  <= kb_mask_ff;
         end else if (idx == `REG_KB_ENABLE_IDX) begin
            avs_readdata[KB_N-1:0] <= kb_pin_en_ff;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // two flops before detection
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_s1_ff <= 1'b1;
         ext_s2_ff <= 1'b1;
         kb_s1_ff  <= {KB_N{1'b1}};
         kb_s2_ff  <= {KB_N{1'b1}};
      end else begin
         ext_s1_ff <= ext_int_pin;
         ext_s2_ff <= ext_s1_ff;
         kb_s1_ff  <= kb_pin;
         kb_s2_ff  <= kb_s1_ff;
      end
   end

   // Sync flops reset high, so a pin held low through reset would look like
   // a falling edge once it reaches the second stage; hold edge detection
   // off until the history flop carries a real pin level
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         warm_ff <= 2'h0;
      end else if (warm_ff != `SYNC_WARM) begin
         warm_ff <= warm_ff + 2'h1;
      end
   end

   assign sync_ready = (warm_ff == `SYNC_WARM);

   assign kb_and   = &(kb_s2_ff | ~kb_pin_en_ff);
   assign ext_fall = ext_prev_ff & ~ext_s2_ff & sync_ready;
   // falling edge of AND, follows from it
   assign kb_fall  = kb_and_prev_ff & ~kb_and & sync_ready;

   // ------------------------------------------------------------
   // Acknowledge sources
   // ------------------------------------------------------------
   // break state guards software clears
   assign ack_allow = ~break_state | break_clear_en;
   assign sw_ack_e  = wr_hit & (idx == `REG_STATUS_CTRL_IDX) &
                      avs_writedata[`F_ACK_E] & ack_allow;
   assign sw_ack_k  = wr_hit & (idx == `REG_STATUS_CTRL_IDX) &
                      avs_writedata[`F_ACK_K] & ack_allow;
   assign clr_e     = sw_ack_e | vector_fetch_ack;
   assign clr_k     = sw_ack_k | vector_fetch_ack;

   assign set_e = ext_fall | (ext_level_sel_ff & ~ext_s2_ff);
   // level mode holds while any low
   assign set_k = kb_fall | (kb_level_sel_ff & ~kb_and);

   // ------------------------------------------------------------
   // Request latches
   // ------------------------------------------------------------
   // Set wins over clear so a coincident edge is never lost
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_latch_ff   <= 1'b0;
         kb_latch_ff    <= 1'b0;
         ack_seen_e_ff  <= 1'b0;
         ack_seen_k_ff  <= 1'b0;
         ext_prev_ff    <= 1'b1;
         kb_and_prev_ff <= 1'b1;
      end else begin
         ext_prev_ff    <= ext_s2_ff;
         kb_and_prev_ff <= kb_and;
         // level mode waits for pin high, either order
         if (ext_fall | (ext_level_sel_ff & ~ext_s2_ff & ~ack_seen_e_ff)) begin
            ext_latch_ff <= 1'b1;
         end else if (clr_e | ack_seen_e_ff) begin
            ext_latch_ff <= ext_level_sel_ff & ~ext_s2_ff;
         end
         ack_seen_e_ff <= ext_level_sel_ff & ~ext_s2_ff & ~ext_fall &
                          (clr_e | ack_seen_e_ff);
         if (kb_fall | (kb_level_sel_ff & ~kb_and & ~ack_seen_k_ff)) begin
            kb_latch_ff <= 1'b1;
         end else if (clr_k | ack_seen_k_ff) begin
            kb_latch_ff <= kb_level_sel_ff & ~kb_and;
         end
         ack_seen_k_ff <= kb_level_sel_ff & ~kb_and & ~kb_fall &
                          (clr_k | ack_seen_k_ff);
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // mask gates request; one shared request
   assign cpu_irq        = (ext_latch_ff & ~ext_mask_ff) | (kb_latch_ff & ~kb_mask_ff);
   assign kb_pullup_en   = kb_pin_en_ff;
   assign kb_force_input = kb_pin_en_ff;

   // set_e/set_k summarise the set terms for the level path above
   wire unused_ok = set_e | set_k;

endmodule
`default_nettype wire

// ===== kei_props.sv
`timescale 1ns/1ps
`default_nettype none
module kei_props #(parameter KB_N = 6) (
   input wire logic            ref_clk,
   input wire logic            reset_n,
   input wire logic [3:0]      avs_address,
   input wire logic            avs_read,
   input wire logic            avs_write,
   input wire logic [31:0]     avs_writedata,
   input wire logic [3:0]      avs_byteenable,
   input wire logic [31:0]     avs_readdata,
   input wire logic            avs_waitrequest,
   input wire logic            ext_int_pin,
   input wire logic [KB_N-1:0] kb_pin,
   input wire logic            vector_fetch_ack,
   input wire logic            break_state,
   input wire logic            break_clear_en,
   input wire logic            cpu_irq,
   input wire logic [KB_N-1:0] kb_pullup_en,
   input wire logic [KB_N-1:0] kb_force_input
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Completed write to the control word
   wire logic ctl_wr = avs_write && !avs_waitrequest && avs_address[3:2] == 2'h0 && avs_byteenable[0];
   // Any live source low; disabled keys are ignored
   wire logic pins_lo = !ext_int_pin || |(~kb_pin & kb_pullup_en);
   property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("waitrequest not one cycle");
   property p_ack_rd0; avs_read && !avs_waitrequest && avs_address[3:2] == 2'h0
      |-> avs_readdata[6] == 1'b0 && avs_readdata[2] == 1'b0; endproperty
   a_ack_rd0: assert property (p_ack_rd0) else $error("ack bit read as one");
   property p_rst_quiet; $rose(reset_n) |-> !cpu_irq && kb_pullup_en == '0; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
   property p_pull_in; kb_pullup_en == kb_force_input; endproperty
   a_pull_in: assert property (p_pull_in) else $error("pull-up and input force differ");
   property p_pull_chg; $changed(kb_pullup_en) |-> $past(avs_write && avs_address[3:2] == 2'h1);
   endproperty
   a_pull_chg: assert property (p_pull_chg) else $error("enables moved without write");
   property p_vf; (!pins_lo && !avs_write)[*4] ##0 vector_fetch_ack |=> !cpu_irq; endproperty
   a_vf: assert property (p_vf) else $error("fetch did not clear request");
   property p_mask; ctl_wr && avs_writedata[1] && avs_writedata[5] |=> !cpu_irq; endproperty
   a_mask: assert property (p_mask) else $error("masked request reached cpu");
   property p_brk; break_state && !break_clear_en && ctl_wr && !avs_writedata[1]
      && !avs_writedata[5] && !vector_fetch_ack && cpu_irq |=> cpu_irq; endproperty
   a_brk: assert property (p_brk) else $error("ack took effect in break");
   c_mask: cover property (ctl_wr && avs_writedata[5]);
   c_vf: cover property (vector_fetch_ack && cpu_irq);
   c_brk: cover property (break_state && ctl_wr && cpu_irq);
endmodule
`default_nettype wire

// ===== key_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// Keys pull a line low; a released key reads its pull-up or floats
module key_pad_model (
   input  wire logic       ref_clk,
   input  wire logic       ext_press,
   input  wire logic [5:0] kb_press,
   input  wire logic [5:0] kb_pullup_en,
   output logic            ext_int_pin,
   output logic [5:0]      kb_pin
);
   logic [5:0] float_ff = 6'h15; // Unpulled pins wander so nothing settles by luck
   always @(posedge ref_clk) float_ff <= ~float_ff;
   assign kb_pin = ~kb_press & (kb_pullup_en | float_ff);
   assign ext_int_pin = ~ext_press; // Dedicated line idles high
endmodule
`default_nettype wire

// ===== keyboard_external_interrupt_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module keyboard_external_interrupt_tb_top;
   logic ref_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
   logic avs_waitrequest, ext_int_pin, cpu_irq, vf_ack = 1'b0, brk = 1'b0, brk_en = 1'b0;
   logic ext_press = 1'b0;
   logic [5:0]  kb_pin, kb_pullup_en, kb_force_input, kb_press = 6'h00;
   int          failures = 0, cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   keyboard_external_interrupt u_keyboard_external_interrupt (.ref_clk(ref_clk),
      .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_int_pin(ext_int_pin), .kb_pin(kb_pin),
      .vector_fetch_ack(vf_ack), .break_state(brk), .break_clear_en(brk_en), .cpu_irq(cpu_irq),
      .kb_pullup_en(kb_pullup_en), .kb_force_input(kb_force_input));
   key_pad_model u_key_pad_model (.ref_clk(ref_clk), .ext_press(ext_press), .kb_press(kb_press),
      .kb_pullup_en(kb_pullup_en), .ext_int_pin(ext_int_pin), .kb_pin(kb_pin));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Avalon cycle; waitrequest and read data are taken at the rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         failures++;
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd_q, exp);
   endtask
   task automatic irq(input logic exp);
      @(negedge ref_clk);
      chk(cpu_irq, exp);
      @(posedge ref_clk);
   endtask
   task automatic settle; // Covers the two-flop sync plus edge detect
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic t_ext;
      ext_press <= 1'b1;
      settle;
      ext_press <= 1'b0;
      settle;
      irq(1'b1);
      bus(1'b1, 4'h0, 32'h20);
      irq(1'b0);
      rc(4'h0, 32'hA0);
      bus(1'b1, 4'h0, 32'h60);
      rc(4'h0, 32'h20);
      bus(1'b1, 4'h0, 32'h00);
      ext_press <= 1'b1;
      settle;
      rc(4'h0, 32'h80);
      ext_press <= 1'b0;
      settle;
      vf_ack <= 1'b1;
      @(posedge ref_clk);
      vf_ack <= 1'b0;
      irq(1'b0);
      bus(1'b1, 4'h0, 32'h10);
      ext_press <= 1'b1;
      settle;
      bus(1'b1, 4'h0, 32'h50);
      rc(4'h0, 32'h90);
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rc(4'h0, 32'h00);
      ext_press <= 1'b0;
      $display("done external");
   endtask
   task automatic t_kb;
      bus(1'b1, 4'h0, 32'h02);
      bus(1'b1, 4'h4, 32'h03);
      bus(1'b1, 4'h0, 32'h06);
      bus(1'b1, 4'h0, 32'h00);
      chk(kb_force_input, 6'h03);
      kb_press <= 6'h20;
      settle;
      rc(4'h0, 32'h00);
      kb_press <= 6'h21;
      settle;
      rc(4'h0, 32'h08);
      bus(1'b1, 4'h0, 32'h04);
      kb_press <= 6'h23;
      settle;
      rc(4'h0, 32'h00);
      bus(1'b1, 4'h0, 32'h05);
      rc(4'h0, 32'h09);
      bus(1'b1, 4'h0, 32'h05);
      rc(4'h0, 32'h09);
      kb_press <= 6'h00;
      settle;
      rc(4'h0, 32'h01);
      bus(1'b1, 4'h4, 32'h00);
      bus(1'b1, 4'h0, 32'h00);
      $display("done keyboard");
   endtask
   task automatic t_brk;
      ext_press <= 1'b1;
      settle;
      ext_press <= 1'b0;
      brk <= 1'b1;
      bus(1'b1, 4'h0, 32'h40);
      rc(4'h0, 32'h80);
      brk_en <= 1'b1;
      bus(1'b1, 4'h0, 32'h40);
      brk <= 1'b0;
      rc(4'h0, 32'h00);
      $display("done break");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rc(4'h4, 32'h00);
      rc(4'h8, 32'h00);
      t_ext;
      t_kb;
      t_brk;
      test_done;
   end
   initial begin // Hang guard well past the expected run of under two hundred cycles
      repeat (5000) @(posedge ref_clk);
      failures++;
      test_done;
   end
endmodule
bind keyboard_external_interrupt kei_props #(.KB_N(KB_N)) u_kei_props (.ref_clk(ref_clk),
   .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ext_int_pin(ext_int_pin), .kb_pin(kb_pin),
   .vector_fetch_ack(vector_fetch_ack), .break_state(break_state), .cpu_irq(cpu_irq),
   .break_clear_en(break_clear_en), .kb_pullup_en(kb_pullup_en), .kb_force_input(kb_force_input));
`default_nettype wire
